// ---- hw/calcmp_pkg.sv ----
// Purpose: shared constants and types for the calendar alarm compare block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   offsets are register indexes; the port address equals each one directly
package calcmp_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register indexes
    localparam logic [7:0] OFF_HOUR    = 8'h12;
    localparam logic [7:0] OFF_DAY     = 8'h13;
    localparam logic [7:0] OFF_WEEKDAY = 8'h14;
    localparam logic [7:0] OFF_MONTH   = 8'h15;
    localparam logic [7:0] OFF_YEAR    = 8'h16;
    localparam logic [7:0] OFF_CTRL    = 8'h01;
    localparam logic [7:0] OFF_STATUS  = 8'h02;
    localparam logic [7:0] OFF_MASK    = 8'h03;

    // field layout
    localparam int ENABLE_BIT    = 7;
    localparam int PM_BIT        = 5;
    localparam int FMT12_BIT     = 1;
    localparam int ALARM_IRQ_BIT = 0;

    // writable bit masks per register, unused bits read zero
    localparam logic [7:0] MASK_HOUR    = 8'h_BF;
    localparam logic [7:0] MASK_DAY     = 8'h_BF;
    localparam logic [7:0] MASK_WEEKDAY = 8'h_87;
    localparam logic [7:0] MASK_MONTH   = 8'h_9F;
    localparam logic [7:0] MASK_YEAR    = 8'h_FF;
    localparam logic [7:0] MASK_CTRL    = 8'h_03;
    localparam logic [7:0] MASK_EVT     = 8'h_01;

    // values after reset
    localparam logic [7:0] RST_FIELD  = 8'h_00;
    localparam logic [7:0] RST_CTRL   = 8'h_00;
    localparam logic [7:0] RST_MASK   = 8'h_00;
    localparam logic [7:0] RST_STATUS = 8'h_00;

    localparam int NUM_FIELDS = 5;

    // running calendar as seen by the compare, all BCD
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] year;
    } calcmp_time_t;

    typedef struct packed {
        logic              wrStb;
        logic              rdStb;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } calcmp_req_t;

endpackage : calcmp_pkg

// ---- hw/calcmp_field_match.sv ----
// Purpose: one alarm field compare, per-field enable
// Assumes: both values BCD with unused bits already masked
// Notes:   a disabled field always agrees
`timescale 1ns/100ps
`default_nettype none
module calcmp_field_match #(
    parameter int W = 8
) (
    input  wire logic         enable,
    input  wire logic [W-1:0] alarmVal,
    input  wire logic [W-1:0] nowVal,
    output logic              agree
);
    // a zero-width compare would make every field agree silently
    if (W < 1) begin : g_bad_width
        $error("field width must be at least one bit");
    end

    // disabled field drops out of the wired and
    assign agree = !enable || (alarmVal == nowVal);
endmodule // calcmp_field_match
`default_nettype wire

// ---- hw/calendar_alarm_compare.sv ----
// Purpose: alarm compare registers for hour, day, weekday, month, year
// Assumes: running calendar arrives BCD on ref_clk, one update per tick
// Notes:   status cleared by reading it; irq is status and mask
// Summary of operation
// - hour alarm bit 7 enables hour comparison when one.
// - in 24-hour format hour alarm bits 5..0 hold BCD 0 to 23.
// - day alarm bit 7 enable, bits 5..0 BCD 1 to 31, bit 6 unused.
// - weekday alarm bit 7 enable, bits 2..0 value 1 to 7.
// - month alarm bit 7 enable, bits 4..0 BCD 1 to 12.
// - year alarm bit 7 enable, bits 6..0 BCD 0 to 79.
// - first full match with irq enable sets flag; interrupt also needs mask bit 0.
// - disabled fields are ignored in the match decision.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module calendar_alarm_compare
    import calcmp_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire calcmp_pkg::calcmp_req_t req,
    output logic [calcmp_pkg::DATA_W-1:0] rdData,
    input  wire calcmp_pkg::calcmp_time_t now,
    output logic                          alarmIrq,
    output logic                          alarmMatch
);
    import calcmp_pkg::*;

    // every check below runs on ref_clk and sleeps through reset
    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    typedef struct packed {
        logic [7:0] hourAlarm;
        logic [7:0] dayAlarm;
        logic [7:0] weekdayAlarm;
        logic [7:0] monthAlarm;
        logic [7:0] yearAlarm;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdData;
        logic       matchPrev;
    } calcmp_state_t;

    calcmp_state_t state;
    calcmp_state_t next_state;

    logic [NUM_FIELDS-1:0] agree;
    logic [NUM_FIELDS-1:0] fieldEn;
    logic [NUM_FIELDS*8-1:0] alarmVec;
    logic [NUM_FIELDS*8-1:0] nowVec;
    logic                  fmt12;
    logic [7:0]            hourNow;
    logic                  allMatch;
    logic                  firstMatch;
    logic                  statusRd;

    // hour width same in both formats: 12h keeps pm flag plus 5 bits, 24h bits 5..0
    assign fmt12   = state.ctrl[FMT12_BIT];
    assign hourNow = fmt12 ? (now.hour & 8'h_3F)
                           : (now.hour & 8'h_3F);

    // per-field enable sits in the top bit of each alarm register
    assign fieldEn = {state.hourAlarm[ENABLE_BIT],
                      state.dayAlarm[ENABLE_BIT],
                      state.weekdayAlarm[ENABLE_BIT],
                      state.monthAlarm[ENABLE_BIT],
                      state.yearAlarm[ENABLE_BIT]};

    // values with enable and unused bits stripped
    assign alarmVec = {state.hourAlarm & 8'h_3F,
                       state.dayAlarm & 8'h_3F,
                       state.weekdayAlarm & 8'h_07,
                       state.monthAlarm & 8'h_1F,
                       state.yearAlarm & 8'h_7F};
    assign nowVec   = {hourNow,
                       now.day & 8'h_3F,
                       now.weekday & 8'h_07,
                       now.month & 8'h_1F,
                       now.year & 8'h_7F};

    // field slicing below assumes byte registers and five fields
    if (DATA_W != 8 || NUM_FIELDS != 5) begin : g_bad_cfg
        $error("unsupported data width or field count");
    end

    // one comparator per field
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIELDS; gi++) begin : g_field
            calcmp_field_match #(
                .W(8)
            ) u_match (
                .enable  (fieldEn[gi]),
                .alarmVal(alarmVec[gi*8 +: 8]),
                .nowVal  (nowVec[gi*8 +: 8]),
                .agree   (agree[gi])
            );
        end
    endgenerate

    // no enabled field means no alarm, else every field would always hit
    assign allMatch   = (&agree) && (|fieldEn);
    assign firstMatch = allMatch && !state.matchPrev;
    assign statusRd   = req.rdStb && (req.addr == OFF_STATUS);

    // register file, status and read path
    always_comb begin
        next_state           = state;
        next_state.matchPrev = allMatch;
        next_state.rdData    = 8'h_00;
        if (req.wrStb) begin
            unique case (req.addr)
                OFF_HOUR:    next_state.hourAlarm    = req.wrData & MASK_HOUR;
                OFF_DAY:     next_state.dayAlarm     = req.wrData & MASK_DAY;
                OFF_WEEKDAY: next_state.weekdayAlarm =
                                 req.wrData & MASK_WEEKDAY;
                OFF_MONTH:   next_state.monthAlarm   = req.wrData & MASK_MONTH;
                OFF_YEAR:    next_state.yearAlarm    = req.wrData & MASK_YEAR;
                OFF_CTRL:    next_state.ctrl         = req.wrData & MASK_CTRL;
                OFF_MASK:    next_state.mask         = req.wrData & MASK_EVT;
                default: ;
            endcase
        end
        if (req.rdStb) begin
            unique case (req.addr)
                OFF_HOUR:    next_state.rdData = state.hourAlarm;
                OFF_DAY:     next_state.rdData = state.dayAlarm;
                OFF_WEEKDAY: next_state.rdData = state.weekdayAlarm;
                OFF_MONTH:   next_state.rdData = state.monthAlarm;
                OFF_YEAR:    next_state.rdData = state.yearAlarm;
                OFF_CTRL:    next_state.rdData = state.ctrl;
                OFF_STATUS:  next_state.rdData = state.status;
                OFF_MASK:    next_state.rdData = state.mask;
                default:     next_state.rdData = 8'h_00;
            endcase
        end
        // read clears, but a new hit in the same cycle wins
        if (statusRd) begin
            next_state.status = 8'h_00;
        end
        if (firstMatch && state.ctrl[ALARM_IRQ_BIT]) begin
            next_state.status[0] = 1'b1;
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= '{hourAlarm: RST_FIELD, dayAlarm: RST_FIELD,
                       weekdayAlarm: RST_FIELD, monthAlarm: RST_FIELD,
                       yearAlarm: RST_FIELD, ctrl: RST_CTRL,
                       status: RST_STATUS, mask: RST_MASK,
                       rdData: 8'h_00, matchPrev: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign rdData     = state.rdData;
    assign alarmIrq   = |(state.status & state.mask);
    assign alarmMatch = allMatch;

    // register file keeps only the documented bits
    chk_hour_bits: assert property (
        (state.hourAlarm & ~MASK_HOUR) == 8'h_00)
        else $error("hour alarm unused bit stored");
    chk_day_bits: assert property (
        (state.dayAlarm & ~MASK_DAY) == 8'h_00)
        else $error("day alarm unused bit stored");
    chk_weekday_bits: assert property (
        (state.weekdayAlarm & 8'h_78) == 8'h_00)
        else $error("weekday unused bits stored");
    chk_month_bits: assert property (
        (state.monthAlarm & 8'h_60) == 8'h_00)
        else $error("month unused bits stored");
    chk_ctrl_bits: assert property (
        (state.ctrl & ~MASK_CTRL) == 8'h_00)
        else $error("control unused bit stored");
    chk_mask_bits: assert property (
        (state.mask & ~MASK_EVT) == 8'h_00)
        else $error("mask unused bit stored");

    // a write lands on the next edge with unused bits dropped
    chk_hour_write: assert property (
        req.wrStb && (req.addr == OFF_HOUR)
        |=> state.hourAlarm == ($past(req.wrData) & MASK_HOUR))
        else $error("hour alarm write lost");
    chk_day_write: assert property (
        req.wrStb && (req.addr == OFF_DAY)
        |=> state.dayAlarm == ($past(req.wrData) & MASK_DAY))
        else $error("day alarm write lost");
    chk_weekday_write: assert property (
        req.wrStb && (req.addr == OFF_WEEKDAY)
        |=> state.weekdayAlarm == ($past(req.wrData) & MASK_WEEKDAY))
        else $error("weekday alarm write lost");
    chk_month_write: assert property (
        req.wrStb && (req.addr == OFF_MONTH)
        |=> state.monthAlarm == ($past(req.wrData) & MASK_MONTH))
        else $error("month alarm write lost");
    chk_year_write: assert property (
        req.wrStb && (req.addr == OFF_YEAR)
        |=> state.yearAlarm == ($past(req.wrData) & MASK_YEAR))
        else $error("year alarm write lost");

    // read data stand one cycle after the strobe, zero otherwise
    chk_hour_read: assert property (
        req.rdStb && (req.addr == OFF_HOUR)
        |=> rdData == $past(state.hourAlarm))
        else $error("hour alarm read wrong");
    chk_day_read: assert property (
        req.rdStb && (req.addr == OFF_DAY)
        |=> rdData == $past(state.dayAlarm))
        else $error("day alarm read wrong");
    chk_weekday_read: assert property (
        req.rdStb && (req.addr == OFF_WEEKDAY)
        |=> rdData == $past(state.weekdayAlarm))
        else $error("weekday alarm read wrong");
    chk_month_read: assert property (
        req.rdStb && (req.addr == OFF_MONTH)
        |=> rdData == $past(state.monthAlarm))
        else $error("month alarm read wrong");
    chk_year_read: assert property (
        req.rdStb && (req.addr == OFF_YEAR)
        |=> rdData == $past(state.yearAlarm))
        else $error("year alarm read wrong");
    chk_rd_idle: assert property (
        !req.rdStb |=> rdData == 8'h_00)
        else $error("read data outside the read cycle");

    // a disabled hour field agrees; a mismatch in any enabled field must block the match
    chk_hour_enable: assert property (
        !state.hourAlarm[ENABLE_BIT] |-> agree[4])
        else $error("disabled hour field blocked match");
    chk_hour_tens: assert property (
        !fmt12 && state.hourAlarm[ENABLE_BIT]
        && (state.hourAlarm[5:0] != now.hour[5:0]) |-> !allMatch)
        else $error("24-hour mismatch ignored");
    chk_hour_pm: assert property (
        state.hourAlarm[ENABLE_BIT]
        && (state.hourAlarm[PM_BIT] != now.hour[PM_BIT]) |-> !allMatch)
        else $error("pm or tens bit mismatch ignored");
    chk_hour_twelve: assert property (
        fmt12 && state.hourAlarm[ENABLE_BIT]
        && (state.hourAlarm[4:0] != now.hour[4:0]) |-> !allMatch)
        else $error("12-hour mismatch ignored");
    chk_day_enable: assert property (
        state.dayAlarm[ENABLE_BIT]
        && (state.dayAlarm[5:0] != now.day[5:0]) |-> !allMatch)
        else $error("day mismatch ignored");
    chk_weekday_enable: assert property (
        state.weekdayAlarm[ENABLE_BIT]
        && (state.weekdayAlarm[2:0] != now.weekday[2:0]) |-> !allMatch)
        else $error("weekday mismatch ignored");
    chk_month_enable: assert property (
        state.monthAlarm[ENABLE_BIT]
        && (state.monthAlarm[4:0] != now.month[4:0]) |-> !allMatch)
        else $error("month mismatch ignored");
    chk_year_enable: assert property (
        state.yearAlarm[ENABLE_BIT]
        && (state.yearAlarm[6:0] != now.year[6:0]) |-> !allMatch)
        else $error("year mismatch ignored");

    // disabled fields drop out; nothing enabled means no alarm
    chk_none_enabled: assert property (
        (fieldEn == '0) |-> !allMatch)
        else $error("match with every field disabled");
    chk_hour_only_hit: assert property (
        state.hourAlarm[ENABLE_BIT] && !state.dayAlarm[ENABLE_BIT]
        && !state.weekdayAlarm[ENABLE_BIT] && !state.monthAlarm[ENABLE_BIT]
        && !state.yearAlarm[ENABLE_BIT]
        && (state.hourAlarm[5:0] == now.hour[5:0]) |-> allMatch)
        else $error("disabled field blocked match");

    // alarm flag: set on the first full match, sticky until read
    chk_first_sets_flag: assert property (
        firstMatch && state.ctrl[ALARM_IRQ_BIT] |=> state.status[0])
        else $error("first match did not set alarm flag");
    chk_no_enable_quiet: assert property (
        !state.ctrl[ALARM_IRQ_BIT] && !state.status[0] |=> !state.status[0])
        else $error("flag set with irq enable clear");
    chk_flag_first_only: assert property (
        !state.status[0] && !firstMatch |=> !state.status[0])
        else $error("flag set without a first match");
    chk_flag_sticky: assert property (
        state.status[0] && !statusRd |=> state.status[0])
        else $error("flag dropped without a status read");
    chk_status_rd_clear: assert property (
        statusRd && !firstMatch |=> !state.status[0])
        else $error("status read did not clear flag");
    chk_status_rd_data: assert property (
        statusRd |=> rdData == $past(state.status))
        else $error("status read returned wrong value");
    chk_irq_follows: assert property (
        alarmIrq == (state.status[0] && state.mask[0]))
        else $error("interrupt output disagrees with status and mask");

    // main scenarios: a hit, a raised interrupt, a read racing a hit,
    // a 12-hour hit and a hit with every field enabled
    cov_alarm_hit: cover property (
        firstMatch && state.ctrl[ALARM_IRQ_BIT]);
    cov_irq_high: cover property (alarmIrq);
    cov_clear_race: cover property (statusRd && firstMatch);
    cov_twelve_hit: cover property (fmt12 && allMatch);
    cov_all_fields: cover property ((&fieldEn) && allMatch);

endmodule // calendar_alarm_compare
`default_nettype wire

// ---- testbench/tb_calendar_alarm_compare.sv ----
// Purpose: self-checking bench for the calendar alarm compare block
// Assumes: read data stands the cycle after the read strobe only
// Notes:   ctrl bit0 irq enable, bit1 12-hour; status read clears it
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_calendar_alarm_compare;
    import calcmp_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst_n   = 1'b0;
    calcmp_req_t  req     = '0;
    calcmp_time_t now     = '0;
    logic [7:0]   rdData;
    logic         alarmIrq;
    logic         alarmMatch;
    int           fails      = 0;
    int           checksDone = 0;
    int           cycles     = 0;
    logic [7:0]   got;

    calendar_alarm_compare i_calendar_alarm_compare (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .req        (req),
        .rdData     (rdData),
        .now        (now),
        .alarmIrq   (alarmIrq),
        .alarmMatch (alarmMatch)
    );

    // 100 MHz clock; cycle ceiling is far above the fewer than two hundred needed
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            closeOut();
        end
    end

    task automatic closeOut();
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one-cycle strobes; a gap cycle keeps each strobe a single driver event
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req.wrStb  <= 1'b1;
        req.addr   <= a;
        req.wrData <= d;
        @(posedge ref_clk);
        req.wrStb  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req.rdStb <= 1'b1;
        req.addr  <= a;
        @(posedge ref_clk);
        req.rdStb <= 1'b0;
        #1 d = rdData;
    endtask

    // match output is combinational, so look just after the edge
    task automatic look(input calcmp_time_t t, input logic e);
        @(posedge ref_clk);
        now <= t;
        #1 `CHK("alarmMatch", e, alarmMatch)
    endtask

    task automatic t_reset();
        logic [7:0] offs [9] = '{OFF_HOUR, OFF_DAY, OFF_WEEKDAY, OFF_MONTH,
            OFF_YEAR, OFF_CTRL, OFF_STATUS, OFF_MASK, 8'h_40};
        foreach (offs[i]) begin
            rd(offs[i], got);
            `CHK("reset value", 8'h_00, got)
        end
    endtask

    // unused bits must read back zero; unmapped space stays empty
    task automatic t_masks();
        logic [7:0] offs [5] = '{OFF_HOUR, OFF_DAY, OFF_WEEKDAY, OFF_MONTH,
            OFF_YEAR};
        logic [7:0] msk [5] = '{8'h_BF, 8'h_BF, 8'h_87, 8'h_9F, 8'h_FF};
        foreach (offs[i]) begin
            wr(offs[i], 8'h_FF);
            rd(offs[i], got);
            `CHK("bits", msk[i], got)
            wr(offs[i], 8'h_00);
        end
        wr(8'h_40, 8'h_5A);
        rd(8'h_40, got);
        `CHK("unmapped", 8'h_00, got)
    endtask

    task automatic t_match();
        calcmp_time_t full = {8'h_17, 8'h_31, 8'h_07, 8'h_12, 8'h_79};
        look({8'h_23, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b0);
        wr(OFF_HOUR, 8'h_A3);
        look({8'h_23, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b1);
        look({8'h_22, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b0);
        wr(OFF_HOUR, 8'h_23);
        look({8'h_23, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b0);
        // 12-hour: bit5 is the afternoon mark, not a tens digit
        wr(OFF_CTRL, 8'h_02);
        wr(OFF_HOUR, 8'h_B1);
        look({8'h_31, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b1);
        look({8'h_11, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b0);
        wr(OFF_CTRL, 8'h_00);
        wr(OFF_HOUR, 8'h_05);
        wr(OFF_DAY, 8'h_B1);
        look({8'h_17, 8'h_31, 8'h_07, 8'h_12, 8'h_79}, 1'b1);
        look({8'h_17, 8'h_30, 8'h_07, 8'h_12, 8'h_79}, 1'b0);
        wr(OFF_WEEKDAY, 8'h_87);
        wr(OFF_MONTH, 8'h_92);
        wr(OFF_YEAR, 8'h_F9);
        look(full, 1'b1);
        look({8'h_17, 8'h_31, 8'h_06, 8'h_12, 8'h_79}, 1'b0);
        look({8'h_17, 8'h_31, 8'h_07, 8'h_11, 8'h_79}, 1'b0);
        look({8'h_17, 8'h_31, 8'h_07, 8'h_12, 8'h_78}, 1'b0);
        wr(OFF_DAY, 8'h_00);
        wr(OFF_WEEKDAY, 8'h_00);
        wr(OFF_MONTH, 8'h_00);
        wr(OFF_YEAR, 8'h_00);
    endtask

    // flag only on the first full match, and only with irq enable set
    task automatic t_alarm(input logic [7:0] c, input logic [7:0] m,
                           input logic ei, input logic [7:0] es);
        wr(OFF_CTRL, c);
        wr(OFF_MASK, m);
        wr(OFF_HOUR, 8'h_88);
        look({8'h_07, 8'h_01, 8'h_01, 8'h_01, 8'h_00}, 1'b0);
        rd(OFF_STATUS, got);
        `CHK("status idle", 8'h_00, got)
        look({8'h_08, 8'h_01, 8'h_01, 8'h_01, 8'h_00}, 1'b1);
        @(posedge ref_clk);
        #1 `CHK("alarmIrq set", ei, alarmIrq)
        rd(OFF_STATUS, got);
        `CHK("status", es, got)
        `CHK("alarmIrq cleared", 1'b0, alarmIrq)
        rd(OFF_STATUS, got);
        `CHK("status again", 8'h_00, got)
    endtask

    // reset in mid-run drops a raised flag and every register
    task automatic t_rst_mid();
        wr(OFF_CTRL, 8'h_01);
        wr(OFF_MASK, 8'h_01);
        look({8'h_07, 8'h_01, 8'h_01, 8'h_01, 8'h_00}, 1'b0);
        look({8'h_08, 8'h_01, 8'h_01, 8'h_01, 8'h_00}, 1'b1);
        @(posedge ref_clk);
        #1 `CHK("alarmIrq before reset", 1'b1, alarmIrq)
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 `CHK("alarmIrq after reset", 1'b0, alarmIrq)
        `CHK("alarmMatch after reset", 1'b0, alarmMatch)
        t_reset();
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_masks();
        t_match();
        t_alarm(8'h_01, 8'h_01, 1'b1, 8'h_01);
        t_alarm(8'h_01, 8'h_00, 1'b0, 8'h_01);
        t_alarm(8'h_00, 8'h_01, 1'b0, 8'h_00);
        t_rst_mid();
        closeOut();
    end
endmodule // tb_calendar_alarm_compare
`undef CHK
`default_nettype wire
